//--- hw/pmicrd_pkg.sv
/*
 * Shared constants of the two-wire register read and lockout link:
 * target address, filler byte, lockout sequence and link timing.
 * Assumes a 100 MHz system clock on both ends.
 */
package pmicrd_pkg;
    // target address after reset
    localparam logic [6:0] PMICRD_ADDR_DEFAULT = 7'h5B;
    // byte returned for locations that hold nothing readable
    localparam logic [7:0] PMICRD_FILL_BYTE = 8'hFF;
    // data byte carried by every lockout write
    localparam logic [7:0] PMICRD_LOCK_DATA = 8'hBD;
    // pointers of the three lockout writes, in order
    localparam logic [7:0] PMICRD_LOCK_PTR0 = 8'hEA;
    localparam logic [7:0] PMICRD_LOCK_PTR1 = 8'hE9;
    localparam logic [7:0] PMICRD_LOCK_PTR2 = 8'hEC;
    // pointer value one past the highest address, where it parks
    localparam logic [8:0] PMICRD_PTR_END = 9'h100;
    // bits in one byte on the wire
    localparam logic [3:0] PMICRD_BYTE_BITS = 4'h8;
    // system clock and link clock periods
    localparam int PMICRD_CLK_PERIOD_NS = 10;
    localparam int PMICRD_LINK_PERIOD_NS = 1000;
    // clock cycles per quarter of a link bit, rounded down
    localparam int PMICRD_QTR_CYC = PMICRD_LINK_PERIOD_NS / (4 * PMICRD_CLK_PERIOD_NS);
    // depth of the read data buffer
    localparam int PMICRD_FIFO_DEPTH = 8;
endpackage

//--- hw/pmicrd_if.sv
/*
 * Two-wire link between the bus master end and the register target end.
 * Both wires are open drain with pull-ups; an enabled driver pulls low.
 */
`timescale 1ns/1ns
`default_nettype none
interface pmicrd_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic t_sda_o;
    logic t_sda_oe;
    logic scl;
    logic sda;

    // wired-and of all drivers with the pull-up
    assign scl = ~(m_scl_oe & ~m_scl_o);
    assign sda = ~((m_sda_oe & ~m_sda_o) | (t_sda_oe & ~t_sda_o));

    modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                    input scl, input sda);
    modport target (output t_sda_o, output t_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

//--- hw/pmicrd_target.sv
/*
 * Register target end of the two-wire link: pointer write, single and
 * auto-increment reads, write strobes and the permanent lockout.
 * Assumes register contents come combinationally from user logic on
 * MCLK_I, and that SYS_RST_I is the power-on reset.
 */
`timescale 1ns/1ns
`default_nettype none
module pmicrd_target
    import pmicrd_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = PMICRD_ADDR_DEFAULT
) (
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    input wire logic CE_I,
    pmicrd_if.target LINK,
    output logic [7:0] REG_ADDR_O,
    input wire logic [7:0] REG_DATA_I,
    input wire logic REG_VALID_I,
    output logic WR_STB_O,
    output logic [7:0] WR_ADDR_O,
    output logic [7:0] WR_DATA_O,
    output logic LOCKED_O
);
    typedef enum logic [3:0] {
        T_IDLE, T_ADDR, T_ADDR_ACK, T_PTR, T_PTR_ACK, T_WDATA, T_DATA_ACK, T_TX, T_TX_ACK
    } pmicrd_tst_t;

    typedef struct packed {
        logic [1:0] s1;     // first sync stage of {scl, sda}
        logic [1:0] s2;     // second sync stage
        logic [1:0] prv;    // previous synced value, for edges
        pmicrd_tst_t st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic [8:0] ptr;
        logic rw;
        logic ack;          // master acknowledged the last byte
        logic first;        // next data byte is the first of its write
        logic [1:0] step;   // lockout writes matched so far
        logic arm;          // lock when the current acknowledge ends
        logic locked;
        logic oe;
        logic wstb;
        logic [7:0] wadr;
        logic [7:0] wdat;
    } pmicrd_tgt_t;

    pmicrd_tgt_t q;
    pmicrd_tgt_t next_q;

    // pointer advance that parks one past the top
    function automatic logic [8:0] ptr_inc(input logic [8:0] p);
        return p[8] ? p : p + 9'h001;
    endfunction

    // expected pointer for a lockout step
    function automatic logic [7:0] lock_ptr(input logic [1:0] s);
        case (s)
            2'h0: return PMICRD_LOCK_PTR0;
            2'h1: return PMICRD_LOCK_PTR1;
            default: return PMICRD_LOCK_PTR2;
        endcase
    endfunction

    // register contents, or fill for anything unreadable or past the top
    function automatic logic [7:0] tx_byte(input logic [8:0] p, input logic v,
                                           input logic [7:0] d);
        return (p[8] | ~v) ? PMICRD_FILL_BYTE : d;
    endfunction

    // next state of the whole target
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda;
        logic [7:0] txb;
        scl_rise = q.s2[1] & ~q.prv[1];
        scl_fall = ~q.s2[1] & q.prv[1];
        start = q.s2[1] & q.prv[1] & q.prv[0] & ~q.s2[0];
        stop = q.s2[1] & q.prv[1] & ~q.prv[0] & q.s2[0];
        sda = q.s2[0];
        txb = tx_byte(q.ptr, REG_VALID_I, REG_DATA_I);
        next_q = q;
        if (CE_I) begin
            next_q.wstb = 1'b0;
            next_q.s1 = {LINK.scl, LINK.sda};
            next_q.s2 = q.s1;
            next_q.prv = q.s2;
            if (q.locked) begin
                next_q.st = T_IDLE;
                next_q.oe = 1'b0;
            end else if (start) begin
                next_q.st = T_ADDR;
                next_q.cnt = 4'h0;
                next_q.oe = 1'b0;
            end else if (stop) begin
                next_q.st = T_IDLE;
                next_q.oe = 1'b0;
            end else begin
                case (q.st)
                    T_ADDR, T_PTR, T_WDATA: begin
                        if (scl_rise) begin
                            next_q.sh = {q.sh[6:0], sda};
                            next_q.cnt = q.cnt + 4'h1;
                        end else if (scl_fall && q.cnt == PMICRD_BYTE_BITS) begin
                            next_q.oe = 1'b1;
                            if (q.st == T_ADDR) begin
                                if (q.sh[7:1] == DEV_ADDR) begin
                                    next_q.rw = q.sh[0];
                                    next_q.first = 1'b1;
                                    next_q.st = T_ADDR_ACK;
                                end else begin
                                    next_q.oe = 1'b0;
                                    next_q.st = T_IDLE;
                                end
                            end else if (q.st == T_PTR) begin
                                next_q.ptr = {1'b0, q.sh};
                                next_q.st = T_PTR_ACK;
                            end else begin
                                next_q.st = T_DATA_ACK;
                                next_q.wstb = ~q.ptr[8];
                                next_q.wadr = q.ptr[7:0];
                                next_q.wdat = q.sh;
                                next_q.ptr = ptr_inc(q.ptr);
                                next_q.first = 1'b0;
                                if (q.first && q.ptr[7:0] == lock_ptr(q.step) && !q.ptr[8]
                                    && q.sh == PMICRD_LOCK_DATA) begin
                                    if (q.step == 2'h2) begin
                                        next_q.arm = 1'b1;
                                    end else begin
                                        next_q.step = q.step + 2'h1;
                                    end
                                end else begin
                                    next_q.step = 2'h0;
                                    next_q.arm = 1'b0;
                                end
                            end
                        end
                    end
                    T_ADDR_ACK: begin
                        if (scl_fall) begin
                            next_q.cnt = 4'h0;
                            if (q.rw) begin
                                next_q.sh = txb;
                                next_q.oe = ~txb[7];
                                next_q.st = T_TX;
                            end else begin
                                next_q.oe = 1'b0;
                                next_q.st = T_PTR;
                            end
                        end
                    end
                    T_PTR_ACK: begin
                        if (scl_fall) begin
                            next_q.oe = 1'b0;
                            next_q.cnt = 4'h0;
                            next_q.st = T_WDATA;
                        end
                    end
                    T_DATA_ACK: begin
                        if (scl_fall) begin
                            next_q.oe = 1'b0;
                            next_q.cnt = 4'h0;
                            if (q.arm) begin
                                next_q.locked = 1'b1;
                                next_q.st = T_IDLE;
                            end else begin
                                next_q.st = T_WDATA;
                            end
                        end
                    end
                    T_TX: begin
                        if (scl_fall) begin
                            if (q.cnt == PMICRD_BYTE_BITS - 4'h1) begin
                                next_q.oe = 1'b0; // free the line for the master
                                next_q.ptr = ptr_inc(q.ptr);
                                next_q.st = T_TX_ACK;
                            end else begin
                                next_q.oe = ~q.sh[6];
                                next_q.sh = {q.sh[6:0], 1'b0};
                                next_q.cnt = q.cnt + 4'h1;
                            end
                        end
                    end
                    T_TX_ACK: begin
                        if (scl_rise) begin
                            next_q.ack = ~sda;
                        end else if (scl_fall) begin
                            next_q.cnt = 4'h0;
                            if (q.ack) begin
                                next_q.sh = txb;
                                next_q.oe = ~txb[7];
                                next_q.st = T_TX;
                            end else begin
                                next_q.oe = 1'b0;
                                next_q.st = T_IDLE;
                            end
                        end
                    end
                    default: begin
                        next_q.st = T_IDLE;
                    end
                endcase
            end
        end
    end

    // all target state; only the power-on reset clears the lockout
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // the target only ever touches the data wire
    assign LINK.t_sda_o = 1'b0;
    assign LINK.t_sda_oe = q.oe;
    assign REG_ADDR_O = q.ptr[7:0];
    assign WR_STB_O = q.wstb;
    assign WR_ADDR_O = q.wadr;
    assign WR_DATA_O = q.wdat;
    assign LOCKED_O = q.locked;
endmodule
`default_nettype wire

//--- hw/pmicrd_master.sv
/*
 * Bus master end of the two-wire link plus its read data buffer.
 * The master makes the link clock from MCLK_I by a divider. Commands
 * are single writes or pointer-then-read runs of CMD_LEN_I bytes, one byte when it is zero.
 * Assumes a pull-up on both wires and one target on the link.
 */
`timescale 1ns/1ns
`default_nettype none
module pmicrd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two, at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr;
    logic [AW:0] rd;
    logic full;
    logic empty;

    // full when pointers differ only in the wrap bit
    assign full = (wr[AW] != rd[AW]) && (wr[AW-1:0] == rd[AW-1:0]);
    assign empty = (wr == rd);
    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o = mem[rd[AW-1:0]];

    // storage and pointers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr <= '0;
            rd <= '0;
        end else if (ce_i) begin
            if (in_valid_i && !full) begin
                mem[wr[AW-1:0]] <= in_data_i;
                wr <= wr + (AW+1)'(1);
            end
            if (out_ready_i && !empty) begin
                rd <= rd + (AW+1)'(1);
            end
        end
    end
endmodule

module pmicrd_master
    import pmicrd_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = PMICRD_ADDR_DEFAULT,
    parameter int QTR_CYC = PMICRD_QTR_CYC,
    parameter int FIFO_DEPTH = PMICRD_FIFO_DEPTH
) (
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    input wire logic CE_I,
    pmicrd_if.master LINK,
    input wire logic CMD_VALID_I,
    output logic CMD_READY_O,
    input wire logic CMD_WRITE_I,
    input wire logic [7:0] CMD_PTR_I,
    input wire logic [7:0] CMD_DATA_I,
    input wire logic [7:0] CMD_LEN_I,
    output logic RD_VALID_O,
    input wire logic RD_READY_I,
    output logic [7:0] RD_DATA_O,
    output logic DONE_O,
    output logic NACK_O
);
    // the target's two-stage sync needs every quarter to last four clocks
    if (QTR_CYC < 4 || QTR_CYC > 255) begin : g_chk
        $error("quarter bit count must lie in 4..255");
    end

    typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_ACK, M_STOP, M_WAIT} pmicrd_mst_t;
    typedef enum logic [2:0] {P_ADDRW, P_PTR, P_WDATA, P_ADDRR, P_RDATA} pmicrd_ph_t;

    typedef struct packed {
        logic s1;           // first sync stage of sda
        logic s2;
        pmicrd_mst_t st;
        pmicrd_ph_t ph;
        logic [1:0] qq;     // quarter of the current symbol
        logic [7:0] tq;     // cycles within the quarter
        logic [2:0] bitn;
        logic [7:0] sh;
        logic smp;          // sda sampled while scl high
        logic [7:0] left;   // read bytes still to fetch
        logic wr;
        logic [7:0] ptr;
        logic [7:0] data;
        logic err;
        logic done;
        logic push;
        logic scl_lo;
        logic sda_lo;
    } pmicrd_mstq_t;

    pmicrd_mstq_t q;
    pmicrd_mstq_t next_q;
    logic fifo_ready;

    // wire levels per symbol and quarter, as {scl_lo, sda_lo}
    function automatic logic [1:0] drive(input pmicrd_mst_t s, input logic [1:0] qq,
                                         input logic d);
        case (s)
            M_START: return (qq == 2'h3) ? 2'b11 : {1'b0, qq == 2'h2};
            M_BIT, M_ACK: return {qq == 2'h0 || qq == 2'h3, ~d};
            M_STOP: return (qq == 2'h0) ? 2'b11 : {1'b0, qq != 2'h3};
            M_WAIT: return 2'b10;
            default: return 2'b00;
        endcase
    endfunction

    // next state of the master
    always_comb begin
        logic adv;
        logic d;
        adv = 1'b0;
        d = 1'b1;
        next_q = q;
        if (CE_I) begin
            next_q.done = 1'b0;
            next_q.push = 1'b0;
            next_q.s1 = LINK.sda;
            next_q.s2 = q.s1;
            case (q.st)
                M_IDLE: begin
                    if (CMD_VALID_I) begin
                        next_q.wr = CMD_WRITE_I;
                        next_q.ptr = CMD_PTR_I;
                        next_q.data = CMD_DATA_I;
                        next_q.left = (CMD_LEN_I == 8'h00) ? 8'h01 : CMD_LEN_I;
                        next_q.err = 1'b0;
                        next_q.ph = P_ADDRW;
                        next_q.st = M_START;
                        next_q.qq = 2'h0;
                        next_q.tq = 8'h00;
                        adv = 1'b1;
                    end
                end
                M_WAIT: begin
                    // hold scl low until the buffer can take a byte
                    if (fifo_ready) begin
                        next_q.st = M_BIT;
                        next_q.bitn = 3'h0;
                        next_q.qq = 2'h0;
                        next_q.tq = 8'h00;
                        adv = 1'b1;
                    end
                end
                default: begin
                    if (q.tq == 8'(QTR_CYC - 1)) begin
                        next_q.tq = 8'h00;
                        next_q.qq = q.qq + 2'h1;
                        adv = 1'b1;
                        if (q.qq == 2'h2) begin
                            next_q.smp = q.s2;
                        end
                        if (q.qq == 2'h3) begin
                            case (q.st)
                                M_START: begin
                                    next_q.st = M_BIT;
                                    next_q.bitn = 3'h0;
                                    next_q.sh = {TARGET_ADDR, q.ph == P_ADDRR};
                                end
                                M_BIT: begin
                                    next_q.sh = {q.sh[6:0], q.smp};
                                    next_q.bitn = q.bitn + 3'h1;
                                    if (q.bitn == 3'h7) begin
                                        next_q.st = M_ACK;
                                        next_q.push = (q.ph == P_RDATA);
                                    end
                                end
                                M_ACK: begin
                                    next_q.bitn = 3'h0;
                                    if (q.ph != P_RDATA && q.smp) begin
                                        next_q.err = 1'b1;
                                        next_q.st = M_STOP;
                                    end else begin
                                        case (q.ph)
                                            P_ADDRW: begin
                                                next_q.ph = P_PTR;
                                                next_q.sh = q.ptr;
                                                next_q.st = M_BIT;
                                            end
                                            P_PTR: begin
                                                next_q.ph = q.wr ? P_WDATA : P_ADDRR;
                                                next_q.sh = q.data;
                                                next_q.st = q.wr ? M_BIT : M_START;
                                            end
                                            P_ADDRR: begin
                                                next_q.ph = P_RDATA;
                                                next_q.st = M_WAIT;
                                            end
                                            P_RDATA: begin
                                                next_q.left = q.left - 8'h01;
                                                next_q.st = (q.left == 8'h01) ? M_STOP : M_WAIT;
                                            end
                                            default: begin
                                                next_q.st = M_STOP;
                                            end
                                        endcase
                                    end
                                end
                                default: begin
                                    next_q.st = M_IDLE;
                                    next_q.done = 1'b1;
                                end
                            endcase
                        end
                    end else begin
                        next_q.tq = q.tq + 8'h01;
                    end
                end
            endcase
            // data bit of the symbol now starting
            if (next_q.st == M_BIT) begin
                d = (next_q.ph == P_RDATA) | next_q.sh[7];
            end else if (next_q.st == M_ACK) begin
                d = (next_q.ph != P_RDATA) | (next_q.left == 8'h01);
            end
            if (adv) begin
                {next_q.scl_lo, next_q.sda_lo} = drive(next_q.st, next_q.qq, d);
            end
        end
    end

    // all master state
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // read bytes wait here for the user
    pmicrd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_pmicrd_fifo (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .ce_i(CE_I),
        .in_valid_i(q.push),
        .in_ready_o(fifo_ready),
        .in_data_i(q.sh),
        .out_valid_o(RD_VALID_O),
        .out_ready_i(RD_READY_I),
        .out_data_o(RD_DATA_O)
    );

    assign LINK.m_scl_o = 1'b0;
    assign LINK.m_scl_oe = q.scl_lo;
    assign LINK.m_sda_o = 1'b0;
    assign LINK.m_sda_oe = q.sda_lo;
    assign CMD_READY_O = (q.st == M_IDLE);
    assign DONE_O = q.done;
    assign NACK_O = q.err;
endmodule
`default_nettype wire

//--- test/pmicrd_chk.sv
/*
 * Wire checker of the link: target drive windows, clashes between both ends and the lockout.
 * Assumes the interface nets as plain inputs, one clock and an active
 * high reset.
 */
`timescale 1ns/1ns
`default_nettype none
module pmicrd_chk (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic m_scl_oe_i,
    input wire logic m_sda_oe_i,
    input wire logic t_sda_oe_i,
    input wire logic scl_i,
    input wire logic locked_i
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // clock wire level, drive windows on the data wire and the lockout level
    property p_scl; !m_scl_oe_i |-> scl_i; endproperty
    a_scl: assert property (p_scl) else $error("scl held");
    property p_hi; scl_i && $past(scl_i) |-> $stable(t_sda_oe_i); endproperty
    a_hi: assert property (p_hi) else $error("sda moved");
    property p_clash; scl_i |-> !(m_sda_oe_i && t_sda_oe_i); endproperty
    a_clash: assert property (p_clash) else $error("sda clash");
    property p_on; $rose(t_sda_oe_i) |-> !scl_i; endproperty
    a_on: assert property (p_on) else $error("late drive");
    property p_off; $fell(t_sda_oe_i) |-> !scl_i; endproperty
    a_off: assert property (p_off) else $error("late release");
    property p_mute; locked_i |-> !t_sda_oe_i; endproperty
    a_mute: assert property (p_mute) else $error("locked drive");
    property p_keep; locked_i |=> locked_i; endproperty
    a_keep: assert property (p_keep) else $error("lock lost");
    property p_arm; $rose(locked_i) |-> !scl_i && $past(t_sda_oe_i, 2); endproperty
    a_arm: assert property (p_arm) else $error("lock off ack");
endmodule
`default_nettype wire

//--- test/pmicrd_tb.sv
/*
 * Bench: both link ends joined, checker beside the link.
 * Assumes a register stand-in where pointers with bits 3:2 set are unmapped.
 */
`timescale 1ns/1ns
`default_nettype none
module pmicrd_tb;
    import pmicrd_pkg::*;
    logic clk, rst, cv, cw, rr, crdy, rv, nack, lock, ws, dn;
    logic [7:0] cp, cd, cl, ra, rdd, wa, wd;
    logic [7:0] seq [3] = '{PMICRD_LOCK_PTR0, PMICRD_LOCK_PTR1, PMICRD_LOCK_PTR2};
    int err_count = 0, n_compared = 0, n_ws = 0, n_dn = 0;
    pmicrd_if lk();
    pmicrd_master #(.QTR_CYC(4)) u_pmicrd_master (.MCLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1),
        .LINK(lk.master), .CMD_VALID_I(cv), .CMD_READY_O(crdy), .CMD_WRITE_I(cw),
        .CMD_PTR_I(cp), .CMD_DATA_I(cd), .CMD_LEN_I(cl), .RD_VALID_O(rv), .RD_READY_I(rr),
        .RD_DATA_O(rdd), .DONE_O(dn), .NACK_O(nack));
    // register stand-in: pointers with bits 3:2 set are unmapped
    pmicrd_target u_pmicrd_target (.MCLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1),
        .LINK(lk.target), .REG_ADDR_O(ra), .REG_DATA_I(ra ^ 8'h3C),
        .REG_VALID_I(ra[3:2] != 2'h3), .WR_STB_O(ws), .WR_ADDR_O(wa), .WR_DATA_O(wd),
        .LOCKED_O(lock));
    pmicrd_chk u_pmicrd_chk (.mclk_i(clk), .sys_rst_i(rst), .m_scl_oe_i(lk.m_scl_oe),
        .m_sda_oe_i(lk.m_sda_oe), .t_sda_oe_i(lk.t_sda_oe), .scl_i(lk.scl), .locked_i(lock));
    // 100 MHz clock
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // count write strobe and done pulses, sampled as they stood before the edge
    always @(posedge clk) begin
        if (ws === 1'b1) n_ws <= n_ws + 1;
        if (dn === 1'b1) n_dn <= n_dn + 1;
    end
    function automatic logic [7:0] ev(input logic [8:0] a);
        return (a[8] || a[3:2] == 2'h3) ? PMICRD_FILL_BYTE : a[7:0] ^ 8'h3C;
    endfunction
    task automatic chk8(input logic [7:0] g, e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("Error %0t %h %h", $time, g, e);
        end
    endtask
    task automatic cmd(input logic w, logic [7:0] p, n = 8'h01, int dly = 0, logic e = 0,
        logic [7:0] d = PMICRD_LOCK_DATA);
        int ws0;
        int dn0;
        ws0 = n_ws;
        dn0 = n_dn;
        @(negedge clk);
        {cv, cw, cp, cd, cl} = {1'b1, w, p, d, n};
        @(negedge clk);
        cv = 0;
        repeat (dly) @(negedge clk);
        for (int i = 0; i < (w | e ? 0 : n); i++) begin
            while (rv !== 1'b1) @(negedge clk);
            chk8(rdd, ev(9'(p) + 9'(i)));
            rr = 1;
            @(negedge clk);
            rr = 0;
            @(negedge clk);
        end
        while (crdy !== 1'b1) @(negedge clk);
        chk8({7'h0, nack}, {7'h0, e});
        // let the pulse counters take the edge that ends the done pulse
        @(negedge clk);
        chk8(8'(n_dn - dn0), 8'h01);
        chk8(8'(n_ws - ws0), {7'h0, w & ~e});
        if (w) begin
            chk8(wa, p);
            chk8(wd, d);
        end
    endtask
    task automatic rst_on;
        rst = 1;
        repeat (6) @(negedge clk);
        rst = 0;
    endtask
    task automatic t_read;
        cmd(0, 8'h03);
        cmd(0, 8'h0C);
        cmd(0, 8'h0A, 8'h05);
        cmd(0, 8'hFA, 8'h09, 2000);
    endtask
    task automatic t_lock;
        cmd(1, seq[0]);
        cmd(1, seq[1], , , , 8'h00);
        cmd(1, seq[1]);
        cmd(1, seq[2]);
        chk8({7'h0, lock}, 8'h00);
        foreach (seq[k]) cmd(1, seq[k]);
        chk8({7'h0, lock}, 8'h01);
        cmd(0, 8'h03, , , 1);
    endtask
    task automatic t_por;
        rst_on();
        chk8({7'h0, lock}, 8'h00);
        cmd(0, 8'h03);
    endtask
    task automatic stop_test;
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // main sequence
    initial begin
        {cv, cw, cp, cd, cl, rr} = '0;
        rst_on();
        t_read();
        t_lock();
        t_por();
        stop_test();
    end
    // watchdog
    initial begin
        #600000;
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
